// [sep_pkg.sv]
package sep_pkg;
  localparam int MEM_DEPTH     = 4096;
  localparam int ADDR_W        = 12;
  localparam int IDPAGE_DEPTH  = 32;
  localparam int IDPAGE_AW     = 5;
  localparam int BYTE_W        = 8;
  localparam int BITCNT_W      = 3;
  localparam logic [BITCNT_W-1:0] BITCNT_RST = 3'h0;
  localparam logic [BYTE_W-1:0]   BYTE_RST   = 8'h00;
  localparam logic [1:0]          PROT_RST   = 2'h0;
  // serial command codes for the minimal decoder
  localparam logic [BYTE_W-1:0] CMD_READ    = 8'h03;
  localparam logic [BYTE_W-1:0] CMD_WRITE   = 8'h02;
  localparam logic [BYTE_W-1:0] CMD_RDSR    = 8'h05;
  localparam logic [BYTE_W-1:0] CMD_WRSR    = 8'h01;
  localparam logic [BYTE_W-1:0] CMD_RDID    = 8'h83;
  localparam logic [BYTE_W-1:0] CMD_WRID    = 8'h82;
  localparam logic [BYTE_W-1:0] CMD_LOCKID  = 8'h8a;
  localparam int STATUS_PROT_LO = 2;
  localparam int STATUS_PROT_HI = 3;
  typedef enum logic [2:0] {
    SEP_CMD, SEP_ADDR_HI, SEP_ADDR_LO, SEP_READ, SEP_WRITE, SEP_STATUS_RD,
    SEP_STATUS_WR, SEP_IGNORE
  } sep_state_t;
endpackage

// [sep_link_if.sv]
`timescale 1ns/1ps
interface sep_link_if;
  import sep_pkg::*;
  logic rise;
  logic fall;
  logic din;
  logic sel;
  logic hold;
  logic sel_start;
  logic sel_end;
  modport front (output rise, output fall, output din, output sel, output hold,
                 output sel_start, output sel_end);
  modport core  (input rise, input fall, input din, input sel, input hold,
                 input sel_start, input sel_end);
endinterface

// [sep_pin_front.sv]
`timescale 1ns/1ps
module sep_pin_front (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // raw pins
  input  wire logic sck,
  input  wire logic sdi,
  input  wire logic sel_n,
  input  wire logic hold_n,
  // to core
  sep_link_if.front lnk
);
  import sep_pkg::*;
  logic [1:0] sck_s, sdi_s, sel_s, hold_s;
  logic       sck_d, sel_d, hold_q;
  logic       armed_r;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sck_s  <= 2'h0;
      sdi_s  <= 2'h0;
      // select resets to its low level: a pin already low at reset is no fresh edge
      sel_s  <= 2'h0;
      hold_s <= 2'h3;
    end else begin
      sck_s  <= {sck_s[0], sck};
      sdi_s  <= {sdi_s[0], sdi};
      sel_s  <= {sel_s[0], sel_n};
      hold_s <= {hold_s[0], hold_n};
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sck_d <= 1'b0;
      sel_d <= 1'b0;
    end else begin
      sck_d <= sck_s[1];
      sel_d <= sel_s[1];
    end
  end
  // selection only counts after a falling edge seen since reset
  always_ff @(posedge clk) begin
    if (!rstn) armed_r <= 1'b0;
    else if (sel_d && !sel_s[1]) armed_r <= 1'b1;
  end
  // hold only changes while sck is low, except that deselect clears it at once; otherwise it waits for sck low
  always_ff @(posedge clk) begin
    if (!rstn || sel_s[1]) hold_q <= 1'b0;
    else if (!sck_s[1]) hold_q <= !hold_s[1];
  end
  assign lnk.sel       = armed_r && !sel_s[1];
  assign lnk.sel_start = sel_d && !sel_s[1] && armed_r;
  assign lnk.sel_end   = !sel_d && sel_s[1];
  assign lnk.hold      = hold_q;
  assign lnk.rise      = sck_s[1] && !sck_d && lnk.sel && !hold_q;
  assign lnk.fall      = !sck_s[1] && sck_d && lnk.sel && !hold_q;
  assign lnk.din       = sdi_s[1];
endmodule

// [sep_eeprom_spi.sv]
`timescale 1ns/1ps
module sep_eeprom_spi #(
  parameter bit HAS_IDPAGE = 1'b1
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // serial pins
  input  wire logic sck,
  input  wire logic sdi,
  input  wire logic sel_n,
  input  wire logic hold_n,
  input  wire logic wp_n,
  output logic      sdo,
  output logic      sdo_oe,
  // power state
  output logic      active_pwr,
  output logic      write_busy
);
  import sep_pkg::*;
  // the address and bit counters must span each array exactly, or accesses would alias
  if (MEM_DEPTH != (1 << ADDR_W) || IDPAGE_DEPTH != (1 << IDPAGE_AW) ||
      BYTE_W != (1 << BITCNT_W)) begin : g_size_chk
    $error("array depth, address width or bit counter width disagree");
  end
  sep_link_if lnk ();
  sep_pin_front u_front (
    .clk    (clk),
    .rstn   (rstn),
    .sck    (sck),
    .sdi    (sdi),
    .sel_n  (sel_n),
    .hold_n (hold_n),
    .lnk    (lnk.front)
  );
  logic [BYTE_W-1:0]  mem [MEM_DEPTH];
  logic [BYTE_W-1:0]  idmem [IDPAGE_DEPTH];
  sep_state_t         state_r;
  logic [BITCNT_W-1:0] bit_r;
  logic [BYTE_W-1:0]  sh_r, out_r;
  logic [ADDR_W-1:0]  addr_r;
  logic               id_r, locked_r, wel_r, pend_r;
  logic               cmd_wr_r, lock_cmd_r;
  logic [1:0]         prot_r;
  logic [1:0]         wp_s;
  logic               sdo_r;
  logic [BYTE_W-1:0]  byte_in, status;
  logic               byte_done;
  always_ff @(posedge clk) begin
    if (!rstn) wp_s <= 2'h3;
    else wp_s <= {wp_s[0], wp_n};
  end
  assign byte_in   = {sh_r[BYTE_W-2:0], lnk.din};
  assign byte_done = lnk.rise && (bit_r == 3'h7);
  assign status    = {wp_s[1], 3'h0, prot_r, wel_r, pend_r};
  // write address inside the protected top area is refused
  function automatic logic prot_hit(input logic [1:0] p, input logic [ADDR_W-1:0] a);
    unique case (p)
      2'h0: prot_hit = 1'b0;
      2'h1: prot_hit = (a[ADDR_W-1:ADDR_W-2] == 2'h3);
      2'h2: prot_hit = a[ADDR_W-1];
      2'h3: prot_hit = 1'b1;
    endcase
  endfunction
  // bit counter and shifter
  always_ff @(posedge clk) begin
    if (!rstn || !lnk.sel) begin
      bit_r <= BITCNT_RST;
      sh_r  <= BYTE_RST;
    end else if (lnk.rise) begin
      bit_r <= bit_r + 3'h1;
      sh_r  <= byte_in;
    end
  end
  // command decoder; hold just freezes rise/fall, so state survives
  always_ff @(posedge clk) begin
    if (!rstn || !lnk.sel) begin
      state_r    <= SEP_CMD;
      addr_r     <= '0;
      id_r       <= 1'b0;
      cmd_wr_r   <= 1'b0;
      lock_cmd_r <= 1'b0;
    end else if (byte_done) begin
      unique case (state_r)
        SEP_CMD: begin
          id_r       <= (byte_in == CMD_RDID) || (byte_in == CMD_WRID) ||
                        (byte_in == CMD_LOCKID);
          cmd_wr_r   <= (byte_in == CMD_WRITE) || (byte_in == CMD_WRID) ||
                        (byte_in == CMD_LOCKID);
          lock_cmd_r <= (byte_in == CMD_LOCKID);
          if (byte_in == CMD_READ || byte_in == CMD_WRITE ||
              (HAS_IDPAGE && (byte_in == CMD_RDID || byte_in == CMD_WRID ||
                              byte_in == CMD_LOCKID)))
            state_r <= SEP_ADDR_HI;
          else if (byte_in == CMD_RDSR) state_r <= SEP_STATUS_RD;
          else if (byte_in == CMD_WRSR) state_r <= SEP_STATUS_WR;
          else state_r <= SEP_IGNORE;
        end
        SEP_ADDR_HI: begin
          addr_r[ADDR_W-1:BYTE_W] <= byte_in[ADDR_W-BYTE_W-1:0];
          state_r <= SEP_ADDR_LO;
        end
        SEP_ADDR_LO: begin
          addr_r[BYTE_W-1:0] <= byte_in;
          state_r <= (pend_r || cmd_wr_r) ? SEP_WRITE : SEP_READ;
        end
        SEP_READ, SEP_WRITE: addr_r <= addr_r + 12'h001;
        default: state_r <= state_r;
      endcase
    end
  end
  // writes land per completed byte while selected
  always_ff @(posedge clk) begin
    if (byte_done && lnk.sel && state_r == SEP_WRITE && wel_r) begin
      if (id_r && !locked_r && !lock_cmd_r)
        idmem[addr_r[IDPAGE_AW-1:0]] <= byte_in;
      else if (!id_r && !prot_hit(prot_r, addr_r))
        mem[addr_r] <= byte_in;
    end
  end
  // status: protect bits frozen while write protect is low
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prot_r   <= PROT_RST;
      wel_r    <= 1'b1;
    end else if (byte_done && lnk.sel && state_r == SEP_STATUS_WR && wp_s[1]) begin
      prot_r <= byte_in[STATUS_PROT_HI:STATUS_PROT_LO];
    end
  end
  // the lock only ever sets; nothing but a reset opens the id page again
  always_ff @(posedge clk) begin
    if (!rstn) begin
      locked_r <= 1'b0;
    end else if (byte_done && state_r == SEP_WRITE && lock_cmd_r && wel_r) begin
      locked_r <= 1'b1;
    end
  end
  assign pend_r = 1'b0;
  // output shifts on serial clock fall only, msb first
  always_ff @(posedge clk) begin
    if (!rstn || !lnk.sel) begin
      out_r <= BYTE_RST;
      sdo_r <= 1'b0;
    end else if (lnk.fall) begin
      if (bit_r == 3'h0) begin
        unique case (state_r)
          SEP_READ: begin
            sdo_r <= id_r ? idmem[addr_r[IDPAGE_AW-1:0]][7] : mem[addr_r][7];
            out_r <= id_r ? {idmem[addr_r[IDPAGE_AW-1:0]][6:0], 1'b0}
                          : {mem[addr_r][6:0], 1'b0};
          end
          SEP_STATUS_RD: begin
            sdo_r <= status[7];
            out_r <= {status[6:0], 1'b0};
          end
          default: begin
            sdo_r <= 1'b0;
            out_r <= BYTE_RST;
          end
        endcase
      end else begin
        sdo_r <= out_r[7];
        out_r <= {out_r[6:0], 1'b0};
      end
    end
  end
  assign sdo        = sdo_r;
  assign sdo_oe     = lnk.sel && !lnk.hold &&
                      (state_r == SEP_READ || state_r == SEP_STATUS_RD);
  assign write_busy = 1'b0;
  assign active_pwr = lnk.sel || write_busy;
endmodule

// [sep_eeprom_spi_assertions.sv]
`timescale 1ns/1ps
module sep_eeprom_spi_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // pins
  input wire logic sck,
  input wire logic sel_n,
  input wire logic hold_n,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic active_pwr,
  input wire logic write_busy
);
  logic prev_sel_r;
  logic seen_fall_r;
  // a select held low through reset is not a falling edge
  always_ff @(posedge clk) begin
    prev_sel_r  <= rstn & sel_n;
    seen_fall_r <= rstn & (seen_fall_r | (prev_sel_r & ~sel_n));
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence desel_s;
    sel_n [*4];
  endsequence
  sequence sel_fall_s;
    $fell(sel_n) ##1 !sel_n [*5];
  endsequence
  sequence hold_s;
    !hold_n [*4];
  endsequence
  chk_desel_float: assert property (desel_s |-> !sdo_oe)
    else $error("sdo driven while deselected");
  chk_standby_pwr: assert property (desel_s |-> !active_pwr)
    else $error("active while deselected");
  chk_active_pwr: assert property (sel_fall_s |-> active_pwr)
    else $error("not active while selected");
  chk_busy_idle: assert property (!write_busy)
    else $error("write busy raised");
  chk_hold_float: assert property (hold_s |-> !sdo_oe)
    else $error("sdo driven in hold");
  chk_hold_steady: assert property (hold_s |=> $stable(sdo))
    else $error("sdo moved in hold");
  chk_sdo_on_fall: assert property (sdo_oe && $past(sdo_oe) && $changed(sdo) |->
    !$past(sck, 2) && ($past(sck, 3) || $past(sck, 4) || $past(sck, 5) || $past(sck, 6)))
    else $error("sdo changed away from clock fall");
  chk_first_fall: assert property (sdo_oe |-> seen_fall_r)
    else $error("sdo driven before first select fall");
endmodule
bind sep_eeprom_spi sep_eeprom_spi_assertions u_chk (.clk(clk), .rstn(rstn), .sck(sck),
  .sel_n(sel_n), .hold_n(hold_n), .sdo(sdo), .sdo_oe(sdo_oe), .active_pwr(active_pwr),
  .write_busy(write_busy));

// [sep_spi_master.sv]
`timescale 1ns/1ps
module sep_spi_master (
  // pins toward the device
  output logic      sck,
  output logic      sdi,
  output logic      sel_n,
  output logic      hold_n,
  // resolved data line
  input  wire logic sdo
);
  initial begin
    sck    = 1'b0;
    sdi    = 1'b0;
    sel_n  = 1'b0;
    hold_n = 1'b1;
  end
  // clock rests low outside frames, 400 ns period
  task automatic bits(input int n);
    repeat (n) begin
      #200 sck = 1'b1;
      #200 sck = 1'b0;
    end
  endtask
  task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sdi = tx[i];
      #200 sck = 1'b1;
      #199 rx[i] = sdo;
      #1 sck = 1'b0;
    end
  endtask
  task automatic sel_lo();
    sel_n = 1'b1;
    #400 sel_n = 1'b0;
    #200;
  endtask
  task automatic sel_hi();
    #200 sel_n = 1'b1;
    sdi = ~sdi;
    #400;
  endtask
  // entered only while selected and with the clock low
  task automatic hold_pause();
    #100 hold_n = 1'b0;
    repeat (2) begin
      #100 sck = 1'b1;
      #100 sck = 1'b0;
      sdi = ~sdi;
    end
    #100 hold_n = 1'b1;
    #100;
  endtask
endmodule

// [tb_spi_eeprom_pin_interface.sv]
`timescale 1ns/1ps
module tb_spi_eeprom_pin_interface;
  import sep_pkg::*;
  logic       clk, rstn, wp_n, sck, sdi, sel_n, hold_n, sdo, sdo_oe, sdo_last, act, busy;
  logic       sdo_line;
  logic [1:0] prot, p;
  logic [7:0] rx, d;
  logic [11:0] a;
  int         n_fail, cmp_count, cyc, seed;
  sep_eeprom_spi u_dut (.clk(clk), .rstn(rstn), .sck(sck), .sdi(sdi), .sel_n(sel_n),
    .hold_n(hold_n), .wp_n(wp_n), .sdo(sdo), .sdo_oe(sdo_oe), .active_pwr(act),
    .write_busy(busy));
  sep_spi_master u_m (.sck(sck), .sdi(sdi), .sel_n(sel_n), .hold_n(hold_n), .sdo(sdo_line));
  // floating line never repeats the last driven bit
  always_ff @(posedge clk) begin
    if (!rstn) sdo_last <= 1'b0;
    else if (sdo_oe) sdo_last <= sdo;
  end
  assign sdo_line = sdo_oe ? sdo : ~sdo_last;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [1:0] prot_after(logic [1:0] old, logic [1:0] nw, logic w);
    return w ? nw : old;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd_addr(input logic [7:0] c, input logic [11:0] ad);
    u_m.sel_lo();
    u_m.xb(c, rx);
    u_m.xb({4'h0, ad[11:8]}, rx);
    u_m.xb(ad[7:0], rx);
  endtask
  task automatic final_report();
    $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    seed = 13293;
    rstn = 1'b0;
    wp_n = 1'b1;
    repeat (2) @(posedge clk);
    #2 rstn = 1'b1;
    repeat (4) @(posedge clk);
    #2;
    repeat (3) u_m.xb(CMD_READ, rx);
    chk({7'h0, sdo_oe}, 8'h00);
    $display("power-up select test done");
    for (int k = 0; k < 4; k++) begin
      a = (k == 2) ? 12'hfff : 12'($random(seed));
      d = 8'($random(seed));
      if (k[0]) a = a & 12'h01f;
      cmd_addr(k[0] ? CMD_WRID : CMD_WRITE, a);
      u_m.xb(d, rx);
      u_m.sel_hi();
      cmd_addr(k[0] ? CMD_RDID : CMD_READ, a);
      u_m.xb(8'h00, rx);
      chk(rx, d);
      chk({6'h0, sdo_oe, act}, 8'h03);
      u_m.sel_hi();
      chk({6'h0, sdo_oe, act}, 8'h00);
    end
    $display("memory and id page test done");
    // once locked, the id page keeps its content against later writes
    cmd_addr(CMD_WRID, 12'h005);
    u_m.xb(d, rx);
    u_m.sel_hi();
    cmd_addr(CMD_LOCKID, 12'h000);
    u_m.xb(8'h02, rx);
    u_m.sel_hi();
    cmd_addr(CMD_WRID, 12'h005);
    u_m.xb(~d, rx);
    u_m.sel_hi();
    cmd_addr(CMD_RDID, 12'h005);
    u_m.xb(8'h00, rx);
    u_m.sel_hi();
    chk(rx, d);
    $display("id page lock test done");
    cmd_addr(CMD_WRITE, 12'h123);
    u_m.xb(d, rx);
    u_m.xb(~d, rx);
    u_m.sel_hi();
    u_m.sel_lo();
    u_m.bits(3);
    u_m.sel_hi();
    cmd_addr(CMD_READ, 12'h123);
    fork
      u_m.hold_pause();
      #300 chk({7'h0, sdo_oe}, 8'h00);
    join
    u_m.xb(8'h00, rx);
    chk(rx, d);
    u_m.xb(8'h00, rx);
    chk(rx, ~d);
    u_m.sel_hi();
    $display("hold and partial byte test done");
    prot = PROT_RST;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      #2 wp_n = (k == 0) ? 1'b1 : 1'($random(seed));
      p = 2'($random(seed));
      u_m.sel_lo();
      u_m.xb(CMD_WRSR, rx);
      u_m.xb({4'h0, p, 2'h0}, rx);
      u_m.sel_hi();
      prot = prot_after(prot, p, wp_n);
      u_m.sel_lo();
      u_m.xb(CMD_RDSR, rx);
      u_m.xb(8'h00, rx);
      u_m.sel_hi();
      chk({6'h0, rx[STATUS_PROT_HI:STATUS_PROT_LO]}, {6'h0, prot});
    end
    $display("protect freeze test done");
    final_report();
  end
endmodule
